// [design/ccs_status_lamps.sv]
// Top: lamp drive, button handling and AXI4-Lite registers of the comm card
// Functional notes
// - The card state lamp is steadily lit while the host link is being set up.
// - Once connected, the card state lamp blinks 0.5 s lit, 0.5 s dark.
// - The card state lamp is dark while the card is disconnected from the host.
// - With wireless enabled in CTRL, the link online lamp is lit exactly while the wireless link is online.
// - Power lamps light only once host power is present.
// - The factory default button restores defaults and local monitoring mode.
// - The reboot button restarts the whole card.
// - With wireless disabled in CTRL, the same link online lamp is lit exactly while the card is fieldbus online.
// - The offline/fault lamp is steadily lit while the card is offline and no fault is given.
// - The offline/fault lamp blinks while neither offline nor online and no fault is given.
// - A configuration length error blinks the offline/fault lamp at 1 Hz.
// - A wrong parameter data error blinks it at 2 Hz.
// - A protocol chip init failure blinks it at 4 Hz.
// - With diagnosis disabled the offline/fault lamp stays dark.
`timescale 1ns/1ps
`default_nettype none
module ccs_status_lamps
   import ccs_pkg::*;
#(
   parameter int unsigned TICK_CNT = TICK_CYCLES,
   parameter int unsigned PULSE_TICKS = PULSE_MS
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Host card connector status
   input wire logic hostPowerOk,
   input wire logic hostLinkActive,
   input wire logic wirelessOnline,
   input wire logic txActive,
   // Buttons, high while pressed
   input wire logic factoryDefaultButton,
   input wire logic cardRebootButton,
   // Lamps, high is lit
   output logic cardStateLamp,
   output logic linkOnlineLamp,
   output logic offlineFaultLamp,
   output logic fieldbusPowerLamp,
   output logic wirelessPowerLamp,
   // Button actions and bus direction
   output logic restoreDefaults,
   output logic cardReboot,
   output logic requestToSend,
   // AXI4-Lite write address and data
   input wire logic [4:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   // AXI4-Lite read
   input wire logic [4:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   // Interrupt
   output logic irq
);
   if (TICK_CNT < 1 || TICK_CNT > 1_000_000) begin : gBadTick
      $error("bad TICK_CNT");
   end
   if (PULSE_TICKS < 1 || PULSE_TICKS > 255) begin : gBadPulse
      $error("bad PULSE_TICKS");
   end

   typedef struct packed {
      logic [19:0] tickCnt;
      logic tick;
      ccs_conn_e conn;
      logic [CTRL_W-1:0] ctrl;
      logic [EV_W-1:0] evStat;
      logic [EV_W-1:0] evEn;
      logic dfltPrev;
      logic rbtPrev;
      logic linkPrev;
      logic pwrPrev;
      logic [7:0] dfltCnt;
      logic [7:0] rbtCnt;
      logic cardStateLamp;
      logic linkOnlineLamp;
      logic offlineFaultLamp;
      logic fbPwrLamp;
      logic wlPwrLamp;
      logic restoreDefaults;
      logic cardReboot;
      logic rts;
      logic awHave;
      logic [4:0] awAddr;
      logic wHave;
      logic [31:0] wData;
      logic [3:0] wStrb;
      logic bValid;
      logic [1:0] bResp;
      logic rValid;
      logic [31:0] rData;
      logic [1:0] rResp;
      logic irq;
      // Registered ready flags
      logic awRdy;
      logic wRdy;
      logic arRdy;
   } ccs_top_s;

   ccs_top_s st_q, st_d;
   logic waveState, wave1, wave2, wave4, waveNotOff;

   // One shared millisecond tick feeds every blinker
   ccs_blinker #(.HALF_TICKS(STATE_HALF_MS / TICK_MS)) uStateBlink (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tick(st_q.tick),
      .wave(waveState)
   );
   ccs_blinker #(.HALF_TICKS(FAULT1_HALF_MS / TICK_MS)) uFault1 (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tick(st_q.tick),
      .wave(wave1)
   );
   ccs_blinker #(.HALF_TICKS(FAULT2_HALF_MS / TICK_MS)) uFault2 (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tick(st_q.tick),
      .wave(wave2)
   );
   ccs_blinker #(.HALF_TICKS(FAULT4_HALF_MS / TICK_MS)) uFault4 (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tick(st_q.tick),
      .wave(wave4)
   );
   ccs_blinker #(.HALF_TICKS(NOTOFF_HALF_MS / TICK_MS)) uNotOff (
      .clk_sys(clk_sys),
      .rst_b(rst_b),
      .tick(st_q.tick),
      .wave(waveNotOff)
   );

   logic [EV_W-1:0] evSet;
   logic [EV_W-1:0] clrMask;
   logic [31:0] rdWord;
   logic rdOk;
   logic wrOk;
   logic [CTRL_W-1:0] ctrlNew;

   always_comb begin
      st_d = st_q;
      evSet = '0;
      clrMask = '0;
      rdWord = 32'h0000_0000;
      rdOk = 1'b1;
      wrOk = 1'b1;
      ctrlNew = st_q.ctrl;

      // Timebase
      st_d.tick = 1'b0;
      if (st_q.tickCnt == 20'(TICK_CNT - 1)) begin
         st_d.tickCnt = 20'h00000;
         st_d.tick = 1'b1;
      end else begin
         st_d.tickCnt = st_q.tickCnt + 20'h00001;
      end

      // Host connection state; link-up comes from software in CTRL
      unique case (st_q.conn)
         CS_OFF: if (hostLinkActive) st_d.conn = CS_CONNECTING;
         CS_CONNECTING: begin
            if (!hostLinkActive) st_d.conn = CS_OFF;
            else if (st_q.ctrl[C_LINK_UP]) st_d.conn = CS_CONNECTED;
         end
         CS_CONNECTED: begin
            if (!hostLinkActive) st_d.conn = CS_OFF;
            else if (!st_q.ctrl[C_LINK_UP]) st_d.conn = CS_CONNECTING;
         end
         default: st_d.conn = CS_OFF;
      endcase

      unique case (st_q.conn)
         CS_CONNECTING: st_d.cardStateLamp = 1'b1;
         CS_CONNECTED: st_d.cardStateLamp = waveState;
         default: st_d.cardStateLamp = 1'b0;
      endcase

      // One online lamp: wireless link when enabled, else fieldbus online state
      if (st_q.ctrl[C_WL_ONLINE]) begin
         st_d.linkOnlineLamp = wirelessOnline;
      end else begin
         st_d.linkOnlineLamp = st_q.ctrl[C_FB_ONLINE];
      end
      st_d.fbPwrLamp = hostPowerOk;
      st_d.wlPwrLamp = hostPowerOk;
      st_d.rts = txActive;

      // Fastest fault pattern takes precedence
      if (!st_q.ctrl[C_DIAG_EN]) begin
         st_d.offlineFaultLamp = 1'b0;
      end else if (st_q.ctrl[C_ASIC_ERR]) begin
         st_d.offlineFaultLamp = wave4;
      end else if (st_q.ctrl[C_PRM_ERR]) begin
         st_d.offlineFaultLamp = wave2;
      end else if (st_q.ctrl[C_CFG_ERR]) begin
         st_d.offlineFaultLamp = wave1;
      end else if (st_q.ctrl[C_FB_OFFLINE]) begin
         st_d.offlineFaultLamp = 1'b1;
      end else if (st_q.ctrl[C_FB_ONLINE]) begin
         st_d.offlineFaultLamp = 1'b0;
      end else begin
         st_d.offlineFaultLamp = waveNotOff;
      end

      // Buttons: rising edge starts a pulse held PULSE_TICKS ms
      st_d.dfltPrev = factoryDefaultButton;
      st_d.rbtPrev = cardRebootButton;
      if (factoryDefaultButton && !st_q.dfltPrev) begin
         st_d.dfltCnt = 8'(PULSE_TICKS);
         evSet[E_DEFAULT] = 1'b1;
      end else if (st_q.tick && st_q.dfltCnt != 8'h00) begin
         st_d.dfltCnt = st_q.dfltCnt - 8'h01;
      end
      if (cardRebootButton && !st_q.rbtPrev) begin
         st_d.rbtCnt = 8'(PULSE_TICKS);
         evSet[E_REBOOT] = 1'b1;
      end else if (st_q.tick && st_q.rbtCnt != 8'h00) begin
         st_d.rbtCnt = st_q.rbtCnt - 8'h01;
      end
      st_d.restoreDefaults = (st_d.dfltCnt != 8'h00);
      st_d.cardReboot = (st_d.rbtCnt != 8'h00);

      st_d.linkPrev = hostLinkActive;
      st_d.pwrPrev = hostPowerOk;
      evSet[E_LINK] = hostLinkActive ^ st_q.linkPrev;
      evSet[E_POWER] = hostPowerOk ^ st_q.pwrPrev;

      // Write channel: address and data taken in either order
      if (s_axi_awvalid && !st_q.awHave) begin
         st_d.awHave = 1'b1;
         st_d.awAddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_q.wHave) begin
         st_d.wHave = 1'b1;
         st_d.wData = s_axi_wdata;
         st_d.wStrb = s_axi_wstrb;
      end
      if (st_q.awHave && st_q.wHave && !st_q.bValid) begin
         unique case (st_q.awAddr)
            ADDR_CTRL: begin
               if (st_q.wStrb[0]) ctrlNew = st_q.wData[CTRL_W-1:0];
            end
            ADDR_IRQ_EN: begin
               if (st_q.wStrb[0]) st_d.evEn = st_q.wData[EV_W-1:0];
            end
            ADDR_IRQ_CLR: begin
               if (st_q.wStrb[0]) clrMask = st_q.wData[EV_W-1:0];
            end
            ADDR_STAT, ADDR_IRQ_STAT, ADDR_ID: wrOk = 1'b1;
            default: wrOk = 1'b0;
         endcase
         st_d.awHave = 1'b0;
         st_d.wHave = 1'b0;
         st_d.bValid = 1'b1;
         st_d.bResp = wrOk ? 2'h0 : 2'h2;
      end else if (st_q.bValid && s_axi_bready) begin
         st_d.bValid = 1'b0;
      end

      // Factory default also returns control to its reset value
      if (st_q.restoreDefaults) ctrlNew = CTRL_RST;
      st_d.ctrl = ctrlNew;

      // Read channel
      unique case (s_axi_araddr)
         ADDR_CTRL: rdWord = {{(32-CTRL_W){1'b0}}, st_q.ctrl};
         ADDR_STAT: rdWord = {24'h000000, st_q.offlineFaultLamp, st_q.linkOnlineLamp,
                              st_q.cardStateLamp, hostPowerOk, wirelessOnline,
                              hostLinkActive, st_q.conn};
         ADDR_IRQ_STAT: rdWord = {{(32-EV_W){1'b0}}, st_q.evStat};
         ADDR_IRQ_EN: rdWord = {{(32-EV_W){1'b0}}, st_q.evEn};
         ADDR_IRQ_CLR: rdWord = 32'h0000_0000;
         ADDR_ID: rdWord = ID_VALUE;
         default: rdOk = 1'b0;
      endcase
      if (s_axi_arvalid && !st_q.rValid) begin
         st_d.rValid = 1'b1;
         st_d.rData = rdOk ? rdWord : 32'h0000_0000;
         st_d.rResp = rdOk ? 2'h0 : 2'h2;
      end else if (st_q.rValid && s_axi_rready) begin
         st_d.rValid = 1'b0;
      end

      // Set wins over clear
      st_d.evStat = (st_q.evStat & ~clrMask) | evSet;
      st_d.irq = |(st_d.evStat & st_d.evEn);

      // Ready outputs come from flops, always the inverse of awHave, wHave and rValid in the same cycle
      st_d.awRdy = ~st_d.awHave;
      st_d.wRdy = ~st_d.wHave;
      st_d.arRdy = ~st_d.rValid;
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
         st_q.ctrl <= CTRL_RST;
         st_q.conn <= CS_OFF;
         st_q.awRdy <= 1'b1;
         st_q.wRdy <= 1'b1;
         st_q.arRdy <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign cardStateLamp = st_q.cardStateLamp;
   assign linkOnlineLamp = st_q.linkOnlineLamp;
   assign offlineFaultLamp = st_q.offlineFaultLamp;
   assign fieldbusPowerLamp = st_q.fbPwrLamp;
   assign wirelessPowerLamp = st_q.wlPwrLamp;
   assign restoreDefaults = st_q.restoreDefaults;
   assign cardReboot = st_q.cardReboot;
   assign requestToSend = st_q.rts;
   assign s_axi_awready = st_q.awRdy;
   assign s_axi_wready = st_q.wRdy;
   assign s_axi_bvalid = st_q.bValid;
   assign s_axi_bresp = st_q.bResp;
   assign s_axi_arready = st_q.arRdy;
   assign s_axi_rvalid = st_q.rValid;
   assign s_axi_rdata = st_q.rData;
   assign s_axi_rresp = st_q.rResp;
   assign irq = st_q.irq;
endmodule
`default_nettype wire

// [design/ccs_pkg.sv]
// Package: register map, field positions and timing constants of the lamp block
package ccs_pkg;
   localparam int unsigned CLK_HZ = 250_000_000;
   // Blink half periods in milliseconds
   localparam int unsigned STATE_HALF_MS = 500;
   localparam int unsigned FAULT1_HALF_MS = 500;
   localparam int unsigned FAULT2_HALF_MS = 250;
   localparam int unsigned FAULT4_HALF_MS = 125;
   localparam int unsigned NOTOFF_HALF_MS = 1000;
   localparam int unsigned TICK_MS = 1;
   localparam int unsigned TICK_CYCLES = CLK_HZ / 1000 * TICK_MS;
   // Button press pulse stretch, in ms ticks
   localparam int unsigned PULSE_MS = 10;

   localparam logic [4:0] ADDR_CTRL = 5'h00;
   localparam logic [4:0] ADDR_STAT = 5'h04;
   localparam logic [4:0] ADDR_IRQ_STAT = 5'h08;
   localparam logic [4:0] ADDR_IRQ_EN = 5'h0c;
   localparam logic [4:0] ADDR_IRQ_CLR = 5'h10;
   localparam logic [4:0] ADDR_ID = 5'h14;
   // Arbitrary neutral identity value
   localparam logic [31:0] ID_VALUE = 32'h0000_c0de;

   // Control fields
   localparam int unsigned C_LINK_UP = 0;
   localparam int unsigned C_WL_ONLINE = 1;
   localparam int unsigned C_FB_ONLINE = 2;
   localparam int unsigned C_FB_OFFLINE = 3;
   localparam int unsigned C_CFG_ERR = 4;
   localparam int unsigned C_PRM_ERR = 5;
   localparam int unsigned C_ASIC_ERR = 6;
   localparam int unsigned C_DIAG_EN = 7;
   localparam int unsigned CTRL_W = 8;
   localparam logic [CTRL_W-1:0] CTRL_RST = 8'h80;

   // Event bits
   localparam int unsigned E_DEFAULT = 0;
   localparam int unsigned E_REBOOT = 1;
   localparam int unsigned E_LINK = 2;
   localparam int unsigned E_POWER = 3;
   localparam int unsigned EV_W = 4;

   typedef enum logic [1:0] {
      CS_OFF = 2'b00,
      CS_CONNECTING = 2'b01,
      CS_CONNECTED = 2'b10
   } ccs_conn_e;
endpackage

// [design/ccs_blinker.sv]
// Square wave generator stepped by a common millisecond tick
`timescale 1ns/1ps
`default_nettype none
module ccs_blinker #(
   parameter int unsigned HALF_TICKS = 500
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Timebase
   input wire logic tick,
   // Output
   output logic wave
);
   if (HALF_TICKS < 1 || HALF_TICKS > 65535) begin : gBadHalf
      $error("bad HALF_TICKS");
   end
   typedef struct packed {
      logic [15:0] cnt;
      logic wave;
   } ccs_blink_s;
   ccs_blink_s st_q, st_d;
   always_comb begin
      st_d = st_q;
      if (tick) begin
         if (st_q.cnt == 16'(HALF_TICKS - 1)) begin
            st_d.cnt = 16'h0000;
            st_d.wave = ~st_q.wave;
         end else begin
            st_d.cnt = st_q.cnt + 16'h0001;
         end
      end
   end
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         st_q <= '0;
      end else begin
         st_q <= st_d;
      end
   end
   assign wave = st_q.wave;
endmodule
`default_nettype wire

// [sim/ccs_host_model.sv]
// Host control board model: power, link, wireless and bus direction lines
`timescale 1ns/1ps
`default_nettype none
module ccs_host_model #(
   parameter int unsigned LAT = 2
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic rst_b,
   // Requests from the bench: {wireless, link, power}
   input wire logic [2:0] want,
   input wire logic txWant,
   // Lines into the card
   output logic hostPowerOk,
   output logic hostLinkActive,
   output logic wirelessOnline,
   output logic txActive
);
   logic [3:0] cur;
   int unsigned cnt;
   // A request must differ from the current lines for LAT+1 cycles, so a slow host can be modelled
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         cur <= 4'h0;
         cnt <= 0;
      end else if ({txWant, want} == cur) begin
         cnt <= 0;
      end else if (cnt >= LAT) begin
         cur <= {txWant, want};
         cnt <= 0;
      end else begin
         cnt <= cnt + 1;
      end
   end
   assign {txActive, wirelessOnline, hostLinkActive, hostPowerOk} = cur;
endmodule
`default_nettype wire

// [sim/ccs_status_lamps_sva.sv]
// Checker: port-level timing of lamps and buttons
`timescale 1ns/1ps
`default_nettype none
module ccs_status_lamps_sva #(
   parameter int unsigned TICK_CNT = 4,
   parameter int unsigned PULSE_TICKS = 2
) (
   // Clock and reset
   input wire logic clk_sys, rst_b,
   // Host lines and buttons
   input wire logic hostPowerOk, hostLinkActive, wirelessOnline, txActive,
   input wire logic factoryDefaultButton, cardRebootButton,
   // Lamps and actions
   input wire logic cardStateLamp, linkOnlineLamp, fieldbusPowerLamp, wirelessPowerLamp,
   input wire logic restoreDefaults, cardReboot, requestToSend
);
   localparam int PMAX = (PULSE_TICKS + 2) * TICK_CNT + 6;
   // Shortest restore pulse: the first tick may follow the press at once
   localparam int DMIN = (PULSE_TICKS - 1) * TICK_CNT + 1;
   logic [31:0] dLen;
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         dLen <= 32'h0000_0000;
      end else if (restoreDefaults) begin
         dLen <= dLen + 32'h0000_0001;
      end else begin
         dLen <= 32'h0000_0000;
      end
   end
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);
   property p_fbpwr; $past(rst_b) |-> fieldbusPowerLamp == $past(hostPowerOk); endproperty
   a_fbpwr: assert property (p_fbpwr) else $error("fieldbus power lamp wrong");
   property p_wlpwr; $past(rst_b) |-> wirelessPowerLamp == $past(hostPowerOk); endproperty
   a_wlpwr: assert property (p_wlpwr) else $error("wireless power lamp wrong");
   property p_rts; $past(rst_b) |-> requestToSend == $past(txActive); endproperty
   a_rts: assert property (p_rts) else $error("request to send wrong");
   property p_link; $past(rst_b) && !$past(wirelessOnline) |-> !linkOnlineLamp; endproperty
   a_link: assert property (p_link) else $error("link lamp lit while offline");
   property p_stoff; (!hostLinkActive) [*3] |-> !cardStateLamp; endproperty
   a_stoff: assert property (p_stoff) else $error("state lamp lit without host");
   property p_dflt; $rose(factoryDefaultButton) |-> ##[1:PMAX] restoreDefaults; endproperty
   a_dflt: assert property (p_dflt) else $error("no restore pulse");
   property p_dlen; $fell(restoreDefaults) |-> dLen >= 32'(DMIN); endproperty
   a_dlen: assert property (p_dlen) else $error("restore pulse too short");
   property p_boot; $rose(cardRebootButton) |-> ##[1:PMAX] cardReboot; endproperty
   a_boot: assert property (p_boot) else $error("no reboot pulse");
   c_boot: cover property ($rose(cardReboot));
   c_link: cover property ($rose(linkOnlineLamp));
   c_state: cover property ($fell(cardStateLamp));
endmodule
`default_nettype wire

// [sim/ccs_status_lamps_tb_top.sv]
// Testbench: lamp patterns, buttons, interrupt and register access
`timescale 1ns/1ps
`default_nettype none
module ccs_status_lamps_tb_top;
   import ccs_pkg::*;
   localparam int TK = 4;
   localparam logic [7:0] CTL [9] = '{8'h80, 8'h90, 8'ha0, 8'hc0, 8'hb0, 8'hf8, 8'h88,
      8'h08, 8'h84};
   localparam int EXP [9] = '{NOTOFF_HALF_MS * TK, FAULT1_HALF_MS * TK, FAULT2_HALF_MS * TK,
      FAULT4_HALF_MS * TK, FAULT2_HALF_MS * TK, FAULT4_HALF_MS * TK, 'hffff, 0, 0};
   logic clk_sys = 1'b0;
   logic rst_b = 1'b0;
   logic factoryDefaultButton = 1'b0, cardRebootButton = 1'b0, txWant = 1'b0;
   logic [2:0] want = 3'h0;
   logic hostPowerOk, hostLinkActive, wirelessOnline, txActive, irq;
   logic cardStateLamp, linkOnlineLamp, offlineFaultLamp, fieldbusPowerLamp, wirelessPowerLamp;
   logic restoreDefaults, cardReboot, requestToSend;
   logic [4:0] s_axi_awaddr = 5'h0, s_axi_araddr = 5'h0;
   logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
   logic [3:0] s_axi_wstrb = 4'hf;
   logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
   logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
   logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0] s_axi_bresp, s_axi_rresp;
   logic [34:0] expq [$];
   logic [31:0] rng = 32'h3ab71e23;
   int n_mismatch = 0;
   int n_compared = 0;

   always #2 clk_sys = ~clk_sys;
   ccs_status_lamps #(.TICK_CNT(TK), .PULSE_TICKS(2)) uut (.*);
   ccs_host_model #(.LAT(2)) host (.*);

   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction
   always @(posedge clk_sys) begin
      rng <= xs(rng);
      txWant <= rng[0];
   end

   task automatic check(input logic [34:0] seen, input logic [34:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   // Bus results are judged against the oldest note
   always @(posedge clk_sys) begin
      if (s_axi_bvalid && s_axi_bready)
         check({1'b0, s_axi_bresp, 32'h0}, expq.pop_front());
      if (s_axi_rvalid && s_axi_rready)
         check({1'b1, s_axi_rresp, s_axi_rdata}, expq.pop_front());
   end

   task automatic wr(input logic [4:0] a, input logic [7:0] d, input logic [1:0] r);
      int n = 0;
      expq.push_back({1'b0, r, 32'h0});
      s_axi_awaddr <= a;
      s_axi_wdata <= {24'h0, d};
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
         n++;
      end while (!s_axi_bvalid && n < 200);
      if (n >= 200) n_mismatch++;
      s_axi_bready <= 1'b0;
      @(posedge clk_sys);
   endtask
   task automatic rd(input logic [4:0] a, input logic [33:0] e);
      int n = 0;
      expq.push_back({1'b1, e});
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      do begin
         @(posedge clk_sys);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
         n++;
      end while (!s_axi_rvalid && n < 200);
      if (n >= 200) n_mismatch++;
      s_axi_rready <= 1'b0;
      @(posedge clk_sys);
   endtask

   function automatic logic lamp(input bit f);
      return f ? offlineFaultLamp : cardStateLamp;
   endfunction
   // Lit length after a fresh rise; ffff is steady lit, 0 is dark
   task automatic meas(input bit f, input logic [15:0] e);
      logic p;
      int n = 0;
      logic [15:0] hi = 16'h0;
      repeat (8) @(posedge clk_sys);
      do begin
         p = lamp(f);
         @(posedge clk_sys);
         n++;
      end while (!(lamp(f) === 1'b1 && p === 1'b0) && n < 9000);
      if (n >= 9000) begin
         hi = (lamp(f) === 1'b1) ? 16'hffff : 16'h0;
      end else begin
         while (lamp(f) === 1'b1 && hi != 16'hffff) begin
            @(posedge clk_sys);
            hi = (hi == 16'd5000) ? 16'hffff : hi + 16'd1;
         end
      end
      check({19'h0, hi}, {19'h0, e});
   endtask

   task automatic irq_is(input logic v);
      repeat (3) @(posedge clk_sys);
      check({34'h0, irq}, {34'h0, v});
   endtask

   task automatic final_report;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   initial begin
      repeat (99000) @(posedge clk_sys);
      n_mismatch++;
      final_report();
   end

   initial begin
      repeat (3) @(posedge clk_sys);
      rst_b <= 1'b1;
      @(posedge clk_sys);
      rd(ADDR_CTRL, {26'h0, CTRL_RST});
      rd(ADDR_ID, {2'b00, ID_VALUE});
      wr(ADDR_ID, 8'h55, 2'b00);
      rd(ADDR_ID, {2'b00, ID_VALUE});
      wr(5'h18, 8'h01, 2'b10);
      rd(5'h18, {2'b10, 32'h0});
      $display("test registers done");
      want <= 3'b011;
      meas(1'b0, 16'hffff);
      wr(ADDR_CTRL, 8'h81, 2'b00);
      meas(1'b0, 16'(STATE_HALF_MS * TK));
      want <= 3'b001;
      meas(1'b0, 16'h0);
      check({34'h0, fieldbusPowerLamp & wirelessPowerLamp}, 35'h1);
      $display("test card state done");
      wr(ADDR_CTRL, 8'h82, 2'b00);
      want <= 3'b101;
      repeat (8) @(posedge clk_sys);
      check({34'h0, linkOnlineLamp}, 35'h1);
      want <= 3'b001;
      repeat (8) @(posedge clk_sys);
      check({34'h0, linkOnlineLamp}, 35'h0);
      $display("test wireless link done");
      // Wireless held online; with its enable off the lamp shows fieldbus state
      want <= 3'b101;
      foreach (CTL[i]) begin
         wr(ADDR_CTRL, CTL[i], 2'b00);
         meas(1'b1, 16'(EXP[i]));
         check({34'h0, linkOnlineLamp}, {34'h0, CTL[i][C_FB_ONLINE]});
      end
      $display("test fault lamp done");
      wr(ADDR_IRQ_EN, 8'h03, 2'b00);
      wr(ADDR_IRQ_CLR, 8'h0f, 2'b00);
      rd(ADDR_IRQ_STAT, 34'h0);
      factoryDefaultButton <= 1'b1;
      repeat (4 + rng[3:0]) @(posedge clk_sys);
      factoryDefaultButton <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rd(ADDR_IRQ_STAT, 34'h1);
      rd(ADDR_CTRL, {26'h0, CTRL_RST});
      irq_is(1'b1);
      wr(ADDR_IRQ_EN, 8'h00, 2'b00);
      irq_is(1'b0);
      wr(ADDR_IRQ_EN, 8'h03, 2'b00);
      irq_is(1'b1);
      wr(ADDR_IRQ_CLR, 8'h01, 2'b00);
      irq_is(1'b0);
      cardRebootButton <= 1'b1;
      repeat (4 + rng[7:4]) @(posedge clk_sys);
      cardRebootButton <= 1'b0;
      repeat (20) @(posedge clk_sys);
      rd(ADDR_IRQ_STAT, 34'h2);
      irq_is(1'b1);
      $display("test buttons and interrupt done");
      final_report();
   end
endmodule

bind ccs_status_lamps ccs_status_lamps_sva #(.TICK_CNT(TICK_CNT), .PULSE_TICKS(PULSE_TICKS))
   chk (.*);
`default_nettype wire
